//--- tb/sdcr_core_assertions.sv
// Purpose: port checks for sdcr_core
// Assumes: decode is judged only in transparent mode
// Notes: bound at the foot
`default_nettype none
module sdcr_core_assertions (
  input wire logic clock,
  input wire logic rstn,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_enable_n,
  input wire logic clock_enable,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [12:0] addr,
  input wire logic register_output_enable_n,
  input wire logic register_latch_enable_n,
  input wire logic [3:0] bank_open,
  input wire logic array_beat,
  input wire logic array_write,
  input wire logic [7:0] write_byte_en,
  input wire logic refresh_strobe,
  input wire logic [12:0] refresh_row,
  input wire logic self_refresh
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [2:0] op = {row_strobe_n, col_strobe_n, write_enable_n};
  // latched mode adds a cycle, so it is left out
  wire logic go = !chip_select_n && !register_output_enable_n && !register_latch_enable_n && !self_refresh;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  a_act_opens: assert property (go && op == 3'h3 && clock_enable
    |=> bank_open[$past({bank_select_high, bank_select_low})]) else $error("no open");
  a_pre_all: assert property (go && op == 3'h2 && addr[10] && clock_enable |=> bank_open == 4'h0)
    else $error("pre all");
  a_ref_pulse: assert property (go && op == 3'h1 && clock_enable |=> refresh_strobe)
    else $error("no refresh");
  a_self_enter: assert property (go && op == 3'h1 && !clock_enable |=> self_refresh)
    else $error("no self");
  a_ref_row_step: assert property (refresh_strobe |-> refresh_row == 13'($past(refresh_row) + 13'h1))
    else $error("row step");
  a_self_quiet: assert property (self_refresh |-> !array_beat && $stable(bank_open))
    else $error("self busy");
  a_desel_quiet: assert property (!register_latch_enable_n && !self_refresh
    && (chip_select_n || register_output_enable_n) |=> !refresh_strobe && (bank_open & ~$past(bank_open)) == 4'h0)
    else $error("deselect");
  a_wen_write: assert property (write_byte_en != 8'h0 |-> array_beat && array_write)
    else $error("stray wen");
  c_self: cover property (self_refresh && refresh_strobe);
  c_wbeat: cover property (array_beat && array_write);
  c_pre: cover property (go && op == 3'h2 && addr[10]);
endmodule
bind sdcr_core sdcr_core_assertions u_chk (.clock, .rstn, .chip_select_n, .row_strobe_n, .col_strobe_n,
  .write_enable_n, .clock_enable, .bank_select_low, .bank_select_high, .addr, .register_output_enable_n,
  .register_latch_enable_n, .bank_open, .array_beat, .array_write, .write_byte_en, .refresh_strobe,
  .refresh_row, .self_refresh);
`default_nettype wire

//--- tb/sdcr_ctrl_model.sv
// Purpose: memory controller model driving the command pins
// Assumes: pins change just after a rising edge
// Notes: idle cycles are selected no-ops
`default_nettype none
module sdcr_ctrl_model (
  input wire logic clock,
  output logic chip_select_n,
  output logic row_strobe_n,
  output logic col_strobe_n,
  output logic write_enable_n,
  output logic clock_enable,
  output logic bank_select_low,
  output logic bank_select_high,
  output logic [12:0] addr,
  output logic [7:0] byte_mask
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = 4'h7;
    {clock_enable, bank_select_high, bank_select_low} = 3'h4;
    addr = 13'h0;
    byte_mask = 8'h0;
  end
  // one edge per command; address inverted afterwards as it is don't-care
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a, input logic [7:0] m);
    @(posedge clock);
    {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} <= c;
    {bank_select_high, bank_select_low} <= b;
    addr <= a;
    byte_mask <= m;
    @(posedge clock);
    {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} <= 4'h7;
    addr <= ~a;
  endtask
  // clock never stops here, so raising it meets the stable-clock need
  task automatic cke(input logic v);
    @(posedge clock);
    clock_enable <= v;
  endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// Purpose: scenario bench for sdcr_core
// Assumes: transparent register unless a scenario sets it
// Notes: codes {cs,ras,cas,we}: 3 act 5 rd 4 wr 6 stop 2 pre 1 ref 0 mode
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic register_output_enable_n = 1'b0;
  logic register_latch_enable_n = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  wire logic chip_select_n, row_strobe_n, col_strobe_n, write_enable_n;
  wire logic clock_enable, bank_select_low, bank_select_high;
  wire logic array_beat, array_write, refresh_strobe, self_refresh;
  wire logic [12:0] addr, refresh_row;
  wire logic [7:0] byte_mask, write_byte_en, read_byte_drive;
  wire logic [31:0] reg_rdata;
  wire logic [3:0] bank_open;
  wire logic [1:0] array_bank;
  wire logic [8:0] array_col;
  int error_cnt = 0;
  int compares = 0;
  int beats = 0;
  int ticks = 0;
  int mark;
  sdcr_ctrl_model u_ctl (.clock, .chip_select_n, .row_strobe_n, .col_strobe_n, .write_enable_n,
    .clock_enable, .bank_select_low, .bank_select_high, .addr, .byte_mask);
  sdcr_core u_dut (.clock, .rstn, .chip_select_n, .row_strobe_n, .col_strobe_n, .write_enable_n,
    .clock_enable, .bank_select_low, .bank_select_high, .addr, .byte_mask, .register_output_enable_n,
    .register_latch_enable_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .bank_open,
    .array_beat, .array_write, .array_bank, .array_col, .write_byte_en, .read_byte_drive,
    .refresh_strobe, .refresh_row, .self_refresh);
  always #5 clock = ~clock;
  always @(posedge clock) begin
    beats <= beats + (array_beat === 1'b1);
    ticks <= ticks + (refresh_strobe === 1'b1);
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk("reg", e, reg_rdata);
  endtask
  task automatic end_of_test;
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic t_write;
    u_ctl.cmd(4'h0, 2'h0, 13'h1002, 8'h0);
    repeat (2) @(posedge clock);
    rc(8'h04, 32'h2);
    u_ctl.cmd(4'h3, 2'h2, 13'h1abc, 8'h0);
    u_ctl.cmd(4'h4, 2'h2, 13'h0406, 8'h0f);
    #1;
    for (int i = 0; i < 4; i++) begin
      chk("beat", 4'he, {array_beat, array_write, array_bank});
      chk("col", 4 + (i + 2) % 4, array_col);
      chk("wen", 8'hf0, write_byte_en);
      @(posedge clock) #1;
    end
    chk("ap", 5'h0, {array_beat, bank_open});
  endtask
  task automatic t_term;
    u_ctl.cmd(4'h0, 2'h0, 13'h0007, 8'h0);
    repeat (2) @(posedge clock);
    u_ctl.cmd(4'h3, 2'h1, 13'h0010, 8'h0);
    u_ctl.cmd(4'h5, 2'h1, 13'h0000, 8'h33);
    #1 chk("rd", 4'h9, {array_beat, array_write, array_bank});
    @(posedge clock) #1 chk("drv", 8'hcc, read_byte_drive);
    u_ctl.cmd(4'h6, 2'h0, 13'h0000, 8'h33);
    repeat (2) @(posedge clock);
    mark = beats;
    repeat (20) @(posedge clock);
    chk("stop", mark, beats);
  endtask
  task automatic t_pre;
    u_ctl.cmd(4'h3, 2'h0, 13'h0111, 8'h0);
    u_ctl.cmd(4'h3, 2'h3, 13'h0333, 8'h0);
    u_ctl.cmd(4'h2, 2'h1, 13'h0000, 8'h0);
    #1 chk("pre1", 4'h9, bank_open);
    rc(8'h1c, 32'h333);
    u_ctl.cmd(4'h2, 2'h1, 13'h0400, 8'h0);
    #1 chk("pre", 4'h0, bank_open);
  endtask
  task automatic t_ref;
    u_ctl.cmd(4'h1, 2'h3, 13'h1fff, 8'h0);
    #1 chk("ref", 14'h2001, {refresh_strobe, refresh_row});
    u_ctl.cmd(4'h9, 2'h0, 13'h0, 8'h0);
    #1 chk("inh", 14'h0001, {refresh_strobe, refresh_row});
    @(posedge clock) register_output_enable_n <= 1'b1;
    u_ctl.cmd(4'h1, 2'h0, 13'h0, 8'h0);
    #1 chk("oe", 1'b0, refresh_strobe);
    @(posedge clock) register_output_enable_n <= 1'b0;
    @(posedge clock) register_latch_enable_n <= 1'b1;
    u_ctl.cmd(4'h3, 2'h0, 13'h0055, 8'h0);
    #1 chk("late", 4'h0, bank_open);
    @(posedge clock) #1 chk("clkd", 4'h1, bank_open);
    @(posedge clock) register_latch_enable_n <= 1'b0;
  endtask
  task automatic t_self;
    rc(8'h0c, 32'h100);
    rc(8'h40, 32'h0);
    wr(8'h0c, 32'h4);
    rc(8'h0c, 32'h4);
    u_ctl.cke(1'b0);
    u_ctl.cmd(4'h1, 2'h0, 13'h0, 8'h0);
    #1 chk("self", 1'b1, self_refresh);
    u_ctl.cmd(4'h3, 2'h2, 13'h0, 8'h0);
    #1 chk("ign", 4'h1, bank_open);
    @(posedge clock) mark = ticks;
    repeat (20) @(posedge clock);
    chk("tick", mark + 4, ticks);
    u_ctl.cke(1'b1);
    repeat (2) @(posedge clock);
    rc(8'h00, 32'h41);
    repeat (10) @(posedge clock);
    rc(8'h00, 32'h01);
    u_ctl.cmd(4'h1, 2'h0, 13'h0, 8'h0);
    #1 chk("ref2", 1'b1, refresh_strobe);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    t_write();
    t_term();
    t_pre();
    t_ref();
    t_self();
    end_of_test();
  end
  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end
endmodule
`default_nettype wire

//--- verilog/sdcr_core.sv
// Purpose: command decode, bank tracking, bursts and refresh
// Assumes: CAS latency two for read drive timing, sequential order
// Notes: data array itself lives outside; this block steers it
`default_nettype none
`include "sdcr_params.svh"
module sdcr_core (
  input wire logic clock,
  input wire logic rstn,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_enable_n,
  input wire logic clock_enable,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [`SDCR_ROW_W-1:0] addr,
  input wire logic [`SDCR_BYTES-1:0] byte_mask,
  input wire logic register_output_enable_n,
  input wire logic register_latch_enable_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic [`SDCR_BANKS-1:0] bank_open,
  output logic array_beat,
  output logic array_write,
  output logic [1:0] array_bank,
  output logic [`SDCR_COL_W-1:0] array_col,
  output logic [`SDCR_BYTES-1:0] write_byte_en,
  output logic [`SDCR_BYTES-1:0] read_byte_drive,
  output logic refresh_strobe,
  output logic [`SDCR_ROW_W-1:0] refresh_row,
  output logic self_refresh
);
  sdcr_pkg::sdcr_state_t q;
  sdcr_pkg::sdcr_state_t nxt_q;

  logic [`SDCR_PIN_W-1:0] pins;
  logic [`SDCR_PIN_W-1:0] pins_r;
  logic pins_valid;

  assign pins = {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n,
                 clock_enable, bank_select_high, bank_select_low, addr, byte_mask};

  sdcr_input_reg #(
    .W(`SDCR_PIN_W)
  ) u_inreg (
    .clock(clock),
    .rstn(rstn),
    .pin_in(pins),
    .register_output_enable_n(register_output_enable_n),
    .register_latch_enable_n(register_latch_enable_n),
    .pin_out(pins_r),
    .pin_out_valid(pins_valid)
  );

  logic cs_n_r;
  logic ras_n_r;
  logic cas_n_r;
  logic we_n_r;
  logic cke_r;
  logic [1:0] bank_r;
  logic [`SDCR_ROW_W-1:0] addr_r;
  logic [`SDCR_BYTES-1:0] mask_r;

  assign {cs_n_r, ras_n_r, cas_n_r, we_n_r, cke_r, bank_r, addr_r, mask_r} = pins_r;

  // command decode; undriven register outputs count as deselect
  logic sel;
  logic cmd_act;
  logic cmd_rd;
  logic cmd_wr;
  logic cmd_bst;
  logic cmd_pre;
  logic cmd_ref;
  logic cmd_mrs;
  logic cmd_ok;

  assign sel = pins_valid & ~cs_n_r;
  assign cmd_ok = sel & cke_r;
  assign cmd_act = cmd_ok & ({ras_n_r, cas_n_r, we_n_r} == 3'b011);
  assign cmd_rd = cmd_ok & ({ras_n_r, cas_n_r, we_n_r} == 3'b101);
  assign cmd_wr = cmd_ok & ({ras_n_r, cas_n_r, we_n_r} == 3'b100);
  assign cmd_bst = cmd_ok & ({ras_n_r, cas_n_r, we_n_r} == 3'b110);
  assign cmd_pre = cmd_ok & ({ras_n_r, cas_n_r, we_n_r} == 3'b010);
  assign cmd_ref = sel & ({ras_n_r, cas_n_r, we_n_r} == 3'b001);
  assign cmd_mrs = cmd_ok & ({ras_n_r, cas_n_r, we_n_r} == 3'b000);

  // burst length minus one from the mode word
  function automatic logic [`SDCR_LEN_W-1:0] len_m1_of(
    input logic [`SDCR_OPC_W-1:0] mode,
    input logic is_wr
  );
    logic [2:0] bl;
    bl = mode[`SDCR_M_BL_MSB:`SDCR_M_BL_LSB];
    len_m1_of = '0;
    if (!(is_wr && mode[`SDCR_M_WR_SINGLE])) begin
      unique case (bl)
        `SDCR_BL_2: len_m1_of = 10'h001;
        `SDCR_BL_4: len_m1_of = 10'h003;
        `SDCR_BL_8: len_m1_of = 10'h007;
        `SDCR_BL_FP: len_m1_of = `SDCR_FULL_PAGE_M1;
        default: len_m1_of = '0;
      endcase
    end
  endfunction

  // next column wraps inside the block of the burst
  function automatic logic [`SDCR_COL_W-1:0] next_col(
    input logic [`SDCR_COL_W-1:0] col,
    input logic [`SDCR_LEN_W-1:0] len_m1
  );
    logic [`SDCR_COL_W-1:0] wrap;
    logic [`SDCR_COL_W-1:0] inc;
    wrap = len_m1[`SDCR_COL_W-1:0];
    inc = col + 9'h001;
    next_col = (col & ~wrap) | (inc & wrap);
  endfunction

  logic [`SDCR_LEN_W-1:0] new_len;
  logic new_fp;
  logic [31:0] rd_mux;
  logic [1:0] row_idx;
  logic row_hit;

  assign new_len = len_m1_of(q.mode, cmd_wr);
  assign new_fp = (new_len == `SDCR_FULL_PAGE_M1);
  assign row_idx = reg_addr[3:2];
  assign row_hit = (reg_addr[7:4] == `SDCR_REG_ROW0 >> 4) && (reg_addr[1:0] == 2'h0);

  always_comb begin
    rd_mux = '0;
    if (reg_addr == `SDCR_REG_STATUS) begin
      rd_mux[`SDCR_BANKS-1:0] = q.bank_open;
      rd_mux[`SDCR_ST_SELF] = q.pwr == sdcr_pkg::SDCR_SELF;
      rd_mux[`SDCR_ST_BURST] = q.burst_on;
      rd_mux[`SDCR_ST_EXIT] = q.pwr == sdcr_pkg::SDCR_EXIT;
    end else if (reg_addr == `SDCR_REG_MODE) begin
      rd_mux[`SDCR_OPC_W-1:0] = q.mode;
    end else if (reg_addr == `SDCR_REG_REFROW) begin
      rd_mux[`SDCR_ROW_W-1:0] = q.ref_row;
    end else if (reg_addr == `SDCR_REG_SRTICK) begin
      rd_mux[15:0] = q.sr_tick;
    end else if (row_hit) begin
      rd_mux[`SDCR_ROW_W-1:0] = q.open_row[row_idx];
    end
  end

  always_comb begin
    nxt_q = q;
    nxt_q.ref_pulse = 1'b0;
    nxt_q.beat = 1'b0;
    nxt_q.wr_en = '0;
    nxt_q.rd_p0 = 1'b0;
    nxt_q.mask_p0 = mask_r;
    // read mask acts two edges after it is registered
    nxt_q.rd_drive = {`SDCR_BYTES{q.rd_p0}} & ~q.mask_p0;
    nxt_q.rdata = reg_read ? rd_mux : 32'h0000_0000;
    if (reg_write && reg_addr == `SDCR_REG_SRTICK) begin
      nxt_q.sr_tick = reg_wdata[15:0];
    end

    unique case (q.pwr)
      sdcr_pkg::SDCR_NORMAL: begin
        // continuing burst beat
        if (q.burst_on) begin
          nxt_q.beat = 1'b1;
          nxt_q.beat_wr = q.burst_wr;
          nxt_q.beat_bank = q.burst_bank;
          nxt_q.beat_col = q.col;
          nxt_q.wr_en = {`SDCR_BYTES{q.burst_wr}} & ~mask_r;
          nxt_q.rd_p0 = ~q.burst_wr;
          nxt_q.col = next_col(q.col, q.len_m1);
          nxt_q.left = q.left - 10'h001;
          if (q.left == 10'h001) begin
            nxt_q.burst_on = 1'b0;
            if (q.burst_ap) begin
              nxt_q.bank_open[q.burst_bank] = 1'b0;
            end
          end
        end
        if (cmd_bst) begin
          // the open row of a cut burst stays open
          nxt_q.burst_on = 1'b0;
          nxt_q.beat = 1'b0;
          nxt_q.wr_en = '0;
          nxt_q.rd_p0 = 1'b0;
          nxt_q.bank_open = q.bank_open;
        end
        if (cmd_act) begin
          nxt_q.bank_open[bank_r] = 1'b1;
          nxt_q.open_row[bank_r] = addr_r;
        end
        if (cmd_rd || cmd_wr) begin
          // a new access replaces any burst in flight
          nxt_q.beat = 1'b1;
          nxt_q.beat_wr = cmd_wr;
          nxt_q.beat_bank = bank_r;
          nxt_q.beat_col = addr_r[`SDCR_COL_W-1:0];
          nxt_q.wr_en = {`SDCR_BYTES{cmd_wr}} & ~mask_r;
          nxt_q.rd_p0 = cmd_rd;
          nxt_q.burst_wr = cmd_wr;
          nxt_q.burst_bank = bank_r;
          nxt_q.len_m1 = new_len;
          nxt_q.left = new_len;
          nxt_q.col = next_col(addr_r[`SDCR_COL_W-1:0], new_len);
          nxt_q.burst_on = new_len != '0;
          nxt_q.burst_ap = addr_r[`SDCR_AP_BIT] & ~new_fp;
          if (new_len == '0 && addr_r[`SDCR_AP_BIT]) begin
            nxt_q.bank_open[bank_r] = 1'b0;
          end
        end
        if (cmd_pre) begin
          if (addr_r[`SDCR_AP_BIT]) begin
            nxt_q.bank_open = '0;
          end else begin
            nxt_q.bank_open[bank_r] = 1'b0;
          end
          if (addr_r[`SDCR_AP_BIT] || bank_r == q.burst_bank) begin
            nxt_q.burst_on = 1'b0;
          end
        end
        if (cmd_mrs) begin
          nxt_q.mode = addr_r[`SDCR_OPC_W-1:0];
        end
        if (cmd_ref && cke_r) begin
          // row comes from the counter, address pins unused
          nxt_q.ref_row = q.ref_row + 13'h0001;
          nxt_q.ref_pulse = 1'b1;
        end else if (cmd_ref) begin
          nxt_q.pwr = sdcr_pkg::SDCR_SELF;
          nxt_q.sr_tmr = q.sr_tick;
          nxt_q.burst_on = 1'b0;
          nxt_q.beat = 1'b0;
          nxt_q.wr_en = '0;
          nxt_q.rd_p0 = 1'b0;
        end
      end
      sdcr_pkg::SDCR_SELF: begin
        // internal timer paces refresh; only clock enable is looked at
        if (q.sr_tmr == 16'h0000) begin
          nxt_q.sr_tmr = q.sr_tick;
          nxt_q.ref_row = q.ref_row + 13'h0001;
          nxt_q.ref_pulse = 1'b1;
        end else begin
          nxt_q.sr_tmr = q.sr_tmr - 16'h0001;
        end
        if (pins_valid && cke_r) begin
          nxt_q.pwr = sdcr_pkg::SDCR_EXIT;
          nxt_q.exit_cnt = 8'(`SDCR_XSR_CYC);
        end
      end
      sdcr_pkg::SDCR_EXIT: begin
        // commands are dropped until the exit time is over
        nxt_q.exit_cnt = q.exit_cnt - 8'h01;
        if (q.exit_cnt == 8'h01) begin
          nxt_q.pwr = sdcr_pkg::SDCR_NORMAL;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.pwr <= sdcr_pkg::SDCR_NORMAL;
      q.sr_tick <= `SDCR_SRTICK_RST;
    end else begin
      q <= nxt_q;
    end
  end

  assign reg_rdata = q.rdata;
  assign bank_open = q.bank_open;
  assign array_beat = q.beat;
  assign array_write = q.beat_wr;
  assign array_bank = q.beat_bank;
  assign array_col = q.beat_col;
  assign write_byte_en = q.wr_en;
  assign read_byte_drive = q.rd_drive;
  assign refresh_strobe = q.ref_pulse;
  assign refresh_row = q.ref_row;
  assign self_refresh = q.pwr == sdcr_pkg::SDCR_SELF;
endmodule
`default_nettype wire

//--- verilog/sdcr_input_reg.sv
// Purpose: input register between the pins and the decoder
// Assumes: pins are driven from the same system clock
// Notes: output enable high leaves the outputs undriven
`default_nettype none
`include "sdcr_params.svh"
module sdcr_input_reg #(
  parameter int W = `SDCR_PIN_W
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [W-1:0] pin_in,
  input wire logic register_output_enable_n,
  input wire logic register_latch_enable_n,
  output logic [W-1:0] pin_out,
  output logic pin_out_valid
);
  typedef struct packed {
    logic [W-1:0] held;
  } sdcr_inreg_t;

  sdcr_inreg_t q;
  sdcr_inreg_t nxt_q;

  // clocked mode keeps the level of the last edge until the next one
  always_comb begin
    nxt_q = q;
    nxt_q.held = pin_in;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= nxt_q;
    end
  end

  // latch enable low bypasses the flops entirely
  assign pin_out = register_latch_enable_n ? q.held : pin_in;
  assign pin_out_valid = ~register_output_enable_n;
endmodule
`default_nettype wire

//--- verilog/sdcr_params.svh
// Purpose: named constants of the command decode and refresh block
// Assumes: 100 MHz system clock shared with the memory controller
// Notes: included by the package and by the modules
// What this block does
// - decode chip select and three strobes
// - clock enable high; refresh low means self
// - mode load takes address bits 0-11
// - activate opens row in selected bank
// - read/write column, bank, auto precharge flag
// - precharge one bank or all banks
// - auto precharge at burst end, not full-page
// - burst terminate truncates latest burst
// - write mask same cycle, read mask two late
// - auto refresh uses internal row counter
// - self refresh ignores all but clock enable
// - input register holds or goes transparent
`ifndef SDCR_PARAMS_SVH
`define SDCR_PARAMS_SVH
`define SDCR_CLK_NS 10
`define SDCR_T_XSR_NS 70
`define SDCR_XSR_CYC ((`SDCR_T_XSR_NS + `SDCR_CLK_NS - 1) / `SDCR_CLK_NS)
`define SDCR_ROW_W 13
`define SDCR_COL_W 9
`define SDCR_OPC_W 12
`define SDCR_BANKS 4
`define SDCR_BYTES 8
`define SDCR_LEN_W 10
`define SDCR_PIN_W 28
`define SDCR_AP_BIT 10
`define SDCR_FULL_PAGE_M1 10'h1ff
`define SDCR_M_BL_LSB 0
`define SDCR_M_BL_MSB 2
`define SDCR_M_WR_SINGLE 9
`define SDCR_BL_1 3'h0
`define SDCR_BL_2 3'h1
`define SDCR_BL_4 3'h2
`define SDCR_BL_8 3'h3
`define SDCR_BL_FP 3'h7
`define SDCR_REG_STATUS 8'h00
`define SDCR_REG_MODE 8'h04
`define SDCR_REG_REFROW 8'h08
`define SDCR_REG_SRTICK 8'h0c
`define SDCR_REG_ROW0 8'h10
`define SDCR_ST_SELF 4
`define SDCR_ST_BURST 5
`define SDCR_ST_EXIT 6
`define SDCR_SRTICK_RST 16'h0100
`endif

//--- verilog/sdcr_pkg.sv
// Purpose: shared types of the command decode and refresh block
// Assumes: sdcr_params.svh defines the widths
// Notes: power states are one-hot
`default_nettype none
`include "sdcr_params.svh"
package sdcr_pkg;
  typedef enum logic [2:0] {
    SDCR_NORMAL = 3'b001,
    SDCR_SELF = 3'b010,
    SDCR_EXIT = 3'b100
  } sdcr_pwr_t;
  typedef struct packed {
    sdcr_pwr_t pwr;
    logic [`SDCR_BANKS-1:0] bank_open;
    logic [`SDCR_BANKS-1:0][`SDCR_ROW_W-1:0] open_row;
    logic [`SDCR_OPC_W-1:0] mode;
    logic [`SDCR_ROW_W-1:0] ref_row;
    logic ref_pulse;
    logic burst_on;
    logic burst_wr;
    logic burst_ap;
    logic [1:0] burst_bank;
    logic [`SDCR_COL_W-1:0] col;
    logic [`SDCR_LEN_W-1:0] left;
    logic [`SDCR_LEN_W-1:0] len_m1;
    logic beat;
    logic beat_wr;
    logic [1:0] beat_bank;
    logic [`SDCR_COL_W-1:0] beat_col;
    logic [`SDCR_BYTES-1:0] wr_en;
    logic rd_p0;
    logic [`SDCR_BYTES-1:0] mask_p0;
    logic [`SDCR_BYTES-1:0] rd_drive;
    logic [15:0] sr_tick;
    logic [15:0] sr_tmr;
    logic [7:0] exit_cnt;
    logic [31:0] rdata;
  } sdcr_state_t;
endpackage
`default_nettype wire
